/* File: design/scm_pkg.sv */
/*
 * Constants shared by the system clock and mode control block.
 * Assumes one 25 MHz clock and a plain register port with 4-bit address.
 */
package scm_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int DIV_W = 6;
    localparam int SYNC_STAGES = 2;

    // Register addresses
    localparam logic [3:0] ADDR_CLOCK_MODE = 4'h0;
    localparam logic [3:0] ADDR_IDLE_FLAGS = 4'h1;

    // Clock mode register fields
    localparam int CM_DIV_LSB = 5;
    localparam int CM_LOW_READY = 3;
    localparam int CM_HIGH_READY = 2;
    localparam int CM_IDLE_ON_HALT = 1;
    localparam int CM_HIGH_SELECT = 0;

    // Idle clock and reset flag register fields
    localparam int IF_SYSCLK_IN_IDLE = 7;
    localparam int IF_RESET_CTRL = 3;
    localparam int IF_LOW_VOLT = 2;
    localparam int IF_LVR_INVALID = 1;
    localparam int IF_WDT_CTRL = 0;

    // Values after reset
    localparam logic [2:0] RST_DIV_SELECT = 3'h0;
    localparam logic RST_IDLE_ON_HALT = 1'b1;
    localparam logic RST_HIGH_SELECT = 1'b1;
    localparam logic RST_SYSCLK_IN_IDLE = 1'b0;
    localparam logic [3:0] RST_FLAGS = 4'h0;

    // Divider codes
    localparam logic [2:0] DIV_CODE_SLOW_MAX = 3'h1;
    // Shift is eight minus the code: 010 gives /64, 111 gives /2
    localparam logic [3:0] DIV_SHIFT_TOP = 4'h8;
    localparam logic [3:0] DIV16_MASK = 4'hf;
    localparam logic [5:0] DIV64_MASK = 6'h3f;

    typedef enum logic [2:0] {
        SCM_RUN,
        SCM_IDLE_CLOCK_OFF,
        SCM_IDLE_CLOCK_ON,
        SCM_DEEP_SLEEP,
        SCM_SLEEP_WDT
    } scm_mode_t;
endpackage

/* File: design/scm_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes inputs are quasi-static levels from outside the clk domain.
 */
`timescale 1ns/1ps
module scm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } scm_sync_state_t;

    scm_sync_state_t s_r;
    scm_sync_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = async_in;
        // First stage only feeds the second
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.stable;
endmodule // scm_sync

/* File: design/scm_clock_mode_ctrl.sv */
/*
 * System clock source, divider, halt mode and reset cause flags.
 * Assumes clk is the fast oscillator, slow oscillator arrives on a pin.
 */
`timescale 1ns/1ps
module scm_clock_mode_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic slow_clk_pin,
    input wire logic fast_osc_stable_pin,
    input wire logic slow_osc_stable_pin,
    input wire logic halt,
    input wire logic wake,
    input wire logic wdt_enabled,
    input wire logic reset_ctrl_event,
    input wire logic low_volt_event,
    input wire logic wdt_ctrl_event,
    input wire logic voltage_reset_config_undefined,
    output logic system_clk_en,
    output logic cpu_clk_en,
    output logic fast_div16_en,
    output logic fast_div64_en,
    output logic wdt_clk_en,
    output logic time_base_en,
    output logic fast_osc_run,
    output logic slow_osc_run,
    output logic cpu_halted,
    output logic sw_reset_req
);
    typedef struct packed {
        logic [2:0] div_select;
        logic idle_on_halt;
        logic high_select;
        logic sysclk_in_idle;
        logic [3:0] flags;
        logic low_ready;
        logic cur_slow;
        logic [2:0] cur_shift;
        logic [5:0] div_cnt;
        scm_pkg::scm_mode_t mode;
        logic [7:0] rdata;
        logic slow_q;
        logic cfg_bad_q;
        logic sw_reset;
    } scm_state_t;

    scm_state_t s_r;
    scm_state_t s_nxt;
    logic [2:0] sync_q;
    logic fast_stable;
    logic slow_stable;
    logic slow_level;
    logic slow_tick;
    logic high_ready;
    logic tgt_slow;
    logic [2:0] tgt_shift;
    logic [5:0] mask;
    logic cur_tick;
    logic cur_ready;
    logic new_ready;
    logic awake;
    logic sys_on;
    logic wr_flags;

    scm_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({slow_clk_pin, slow_osc_stable_pin, fast_osc_stable_pin}),
        .sync_out(sync_q)
    );

    assign fast_stable = sync_q[0];
    assign slow_stable = sync_q[1];
    assign slow_level = sync_q[2];
    assign slow_tick = slow_level & ~s_r.slow_q;
    assign awake = (s_r.mode != scm_pkg::SCM_DEEP_SLEEP) &&
        (s_r.mode != scm_pkg::SCM_SLEEP_WDT);
    // Fast source released in either sleep mode, or once the slow source really drives
    assign fast_osc_run = awake && !(s_r.cur_slow && tgt_slow);
    assign high_ready = fast_stable & fast_osc_run;
    assign tgt_slow = !s_r.high_select &&
        (s_r.div_select <= scm_pkg::DIV_CODE_SLOW_MAX);
    assign tgt_shift = s_r.high_select ? 3'h0 :
        3'(scm_pkg::DIV_SHIFT_TOP - {1'b0, s_r.div_select});
    assign mask = 6'((7'h1 << s_r.cur_shift) - 7'h1);
    assign cur_tick = s_r.cur_slow ? slow_tick :
        (high_ready && ((s_r.div_cnt & mask) == mask));
    assign cur_ready = s_r.cur_slow ? s_r.low_ready : high_ready;
    assign new_ready = tgt_slow ? s_r.low_ready : high_ready;
    assign sys_on = (s_r.mode == scm_pkg::SCM_RUN) ||
        (s_r.mode == scm_pkg::SCM_IDLE_CLOCK_ON);
    assign wr_flags = wr && (addr == scm_pkg::ADDR_IDLE_FLAGS);

    always_comb begin
        s_nxt = s_r;
        s_nxt.slow_q = slow_level;
        s_nxt.div_cnt = high_ready ? 6'(s_r.div_cnt + 6'h1) : 6'h0;
        // Switch only at an old-source edge, or when the old one is dead
        if (((tgt_slow != s_r.cur_slow) ||
             (!tgt_slow && (tgt_shift != s_r.cur_shift))) &&
            new_ready && (cur_tick || !cur_ready)) begin
            s_nxt.cur_slow = tgt_slow;
            s_nxt.cur_shift = tgt_shift;
        end
        if ((s_r.mode == scm_pkg::SCM_DEEP_SLEEP) || !slow_stable) begin
            s_nxt.low_ready = 1'b0;
        end else if (slow_tick) begin
            s_nxt.low_ready = 1'b1;
        end
        case (s_r.mode)
            scm_pkg::SCM_RUN: begin
                if (halt) begin
                    if (s_r.idle_on_halt) begin
                        s_nxt.mode = s_r.sysclk_in_idle ?
                            scm_pkg::SCM_IDLE_CLOCK_ON :
                            scm_pkg::SCM_IDLE_CLOCK_OFF;
                    end else begin
                        s_nxt.mode = wdt_enabled ? scm_pkg::SCM_SLEEP_WDT :
                            scm_pkg::SCM_DEEP_SLEEP;
                    end
                end
            end
            scm_pkg::SCM_IDLE_CLOCK_OFF,
            scm_pkg::SCM_IDLE_CLOCK_ON,
            scm_pkg::SCM_DEEP_SLEEP,
            scm_pkg::SCM_SLEEP_WDT: begin
                if (wake) begin
                    s_nxt.mode = scm_pkg::SCM_RUN;
                end
            end
            default: begin
                s_nxt.mode = scm_pkg::SCM_RUN;
            end
        endcase
        if (wr && (addr == scm_pkg::ADDR_CLOCK_MODE)) begin
            s_nxt.div_select = wdata[scm_pkg::CM_DIV_LSB +: 3];
            s_nxt.idle_on_halt = wdata[scm_pkg::CM_IDLE_ON_HALT];
            s_nxt.high_select = wdata[scm_pkg::CM_HIGH_SELECT];
        end
        if (wr_flags) begin
            s_nxt.sysclk_in_idle = wdata[scm_pkg::IF_SYSCLK_IN_IDLE];
            // Writes can only clear; a one leaves the flag alone
            s_nxt.flags = s_r.flags & wdata[3:0];
        end
        // Set after clear so a same-cycle event wins
        if (reset_ctrl_event) begin
            s_nxt.flags[scm_pkg::IF_RESET_CTRL] = 1'b1;
        end
        if (low_volt_event) begin
            s_nxt.flags[scm_pkg::IF_LOW_VOLT] = 1'b1;
        end
        if (voltage_reset_config_undefined) begin
            s_nxt.flags[scm_pkg::IF_LVR_INVALID] = 1'b1;
        end
        if (wdt_ctrl_event) begin
            s_nxt.flags[scm_pkg::IF_WDT_CTRL] = 1'b1;
        end
        s_nxt.cfg_bad_q = voltage_reset_config_undefined;
        s_nxt.sw_reset = voltage_reset_config_undefined &&
            !s_r.cfg_bad_q;
        s_nxt.rdata = 8'h00;
        if (rd && (addr == scm_pkg::ADDR_CLOCK_MODE)) begin
            s_nxt.rdata = {s_r.div_select, 1'b0, s_r.low_ready,
                high_ready, s_r.idle_on_halt, s_r.high_select};
        end else if (rd && (addr == scm_pkg::ADDR_IDLE_FLAGS)) begin
            s_nxt.rdata = {s_r.sysclk_in_idle, 3'h0, s_r.flags};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.div_select <= scm_pkg::RST_DIV_SELECT;
            s_r.idle_on_halt <= scm_pkg::RST_IDLE_ON_HALT;
            s_r.high_select <= scm_pkg::RST_HIGH_SELECT;
            s_r.sysclk_in_idle <= scm_pkg::RST_SYSCLK_IN_IDLE;
            s_r.flags <= scm_pkg::RST_FLAGS;
            s_r.low_ready <= 1'b0;
            s_r.cur_slow <= 1'b0;
            s_r.cur_shift <= 3'h0;
            s_r.div_cnt <= 6'h0;
            s_r.mode <= scm_pkg::SCM_RUN;
            s_r.rdata <= 8'h00;
            s_r.slow_q <= 1'b0;
            s_r.cfg_bad_q <= 1'b0;
            s_r.sw_reset <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // System clock runs in idle-on, stops in idle-off and sleep
    assign system_clk_en = cur_tick && sys_on;
    assign cpu_clk_en = cur_tick && (s_r.mode == scm_pkg::SCM_RUN);
    // Derived clocks die with the fast oscillator
    assign fast_div16_en = high_ready &&
        (s_r.div_cnt[3:0] == scm_pkg::DIV16_MASK);
    assign fast_div64_en = high_ready &&
        (s_r.div_cnt == scm_pkg::DIV64_MASK);
    assign slow_osc_run = s_r.mode != scm_pkg::SCM_DEEP_SLEEP;
    assign wdt_clk_en = slow_tick && slow_osc_run;
    assign time_base_en = slow_tick && awake;
    assign cpu_halted = s_r.mode != scm_pkg::SCM_RUN;
    assign sw_reset_req = s_r.sw_reset;
    assign rdata = s_r.rdata;

    AST_FAST_STOP: assert property (@(posedge clk) disable iff (rst)
        (s_r.cur_slow && tgt_slow) |-> !fast_osc_run && !fast_div16_en)
        else $error("fast oscillator runs under slow clock");
    AST_DIV64_GAP: assert property (@(posedge clk) disable iff (rst)
        (fast_div64_en) |=> !fast_div64_en [*8])
        else $error("div64 pulses too close");
    AST_UNDIV: assert property (@(posedge clk) disable iff (rst)
        (!s_r.cur_slow && s_r.cur_shift == 3'h0 && high_ready && sys_on)
        |-> system_clk_en)
        else $error("undivided fast clock missed a cycle");
    AST_DIV_MAP: assert property (@(posedge clk) disable iff (rst)
        !s_r.high_select |->
        (s_r.div_select != 3'h2 || tgt_shift == 3'h6) &&
        (s_r.div_select != 3'h7 || tgt_shift == 3'h1))
        else $error("divider code maps to wrong ratio");
    AST_SLOW_SEL: assert property (@(posedge clk) disable iff (rst)
        (s_r.cur_slow && system_clk_en) |-> slow_tick)
        else $error("slow source tick from wrong clock");
    AST_LOW_READY: assert property (@(posedge clk) disable iff (rst)
        (s_r.mode == scm_pkg::SCM_DEEP_SLEEP) |=> !s_r.low_ready)
        else $error("low ready set in deep sleep");
    AST_SLOW_WAIT: assert property (@(posedge clk) disable iff (rst)
        (!s_r.cur_slow ##1 s_r.cur_slow) |-> $past(s_r.low_ready))
        else $error("slow switch before low ready");
    AST_HALT_IDLE: assert property (@(posedge clk) disable iff (rst)
        (s_r.mode == scm_pkg::SCM_RUN && halt && s_r.idle_on_halt &&
         !s_r.sysclk_in_idle) |=>
        (s_r.mode == scm_pkg::SCM_IDLE_CLOCK_OFF) && !system_clk_en)
        else $error("idle clock off entry wrong");
    AST_HALT_SLEEP: assert property (@(posedge clk) disable iff (rst)
        (s_r.mode == scm_pkg::SCM_RUN && halt && !s_r.idle_on_halt &&
         wdt_enabled) |=> (s_r.mode == scm_pkg::SCM_SLEEP_WDT))
        else $error("sleep with watchdog not entered");
    AST_IDLE_ON: assert property (@(posedge clk) disable iff (rst)
        (s_r.mode == scm_pkg::SCM_IDLE_CLOCK_ON && cur_tick) |->
        system_clk_en && !cpu_clk_en)
        else $error("idle clock on gating wrong");
    AST_FLAG_NO_SET: assert property (@(posedge clk) disable iff (rst)
        (wr_flags && !s_r.flags[scm_pkg::IF_RESET_CTRL] &&
         !reset_ctrl_event) |=> !s_r.flags[scm_pkg::IF_RESET_CTRL])
        else $error("write set reset control flag");
    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
        (s_r.flags[scm_pkg::IF_WDT_CTRL] && !wr_flags) |=>
        s_r.flags[scm_pkg::IF_WDT_CTRL])
        else $error("watchdog control flag lost");
    AST_LVR_EVT: assert property (@(posedge clk) disable iff (rst)
        low_volt_event |=> s_r.flags[scm_pkg::IF_LOW_VOLT])
        else $error("low voltage flag not set");
    AST_BAD_CFG: assert property (@(posedge clk) disable iff (rst)
        $rose(voltage_reset_config_undefined) |=>
        sw_reset_req && s_r.flags[scm_pkg::IF_LVR_INVALID])
        else $error("bad voltage config not handled");
    AST_RD_ZERO: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == scm_pkg::ADDR_IDLE_FLAGS) |=>
        (rdata[6:4] == 3'h0))
        else $error("unimplemented bits not zero");
    AST_RD_BIT4: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == scm_pkg::ADDR_CLOCK_MODE) |=> !rdata[4])
        else $error("clock mode bit 4 not zero");
    AST_HIGH_READY: assert property (@(posedge clk) disable iff (rst)
        !fast_osc_run |-> !high_ready)
        else $error("high ready without fast oscillator");

    COV_SLOW: cover property (@(posedge clk) disable iff (rst)
        !s_r.cur_slow ##1 s_r.cur_slow);
    COV_DEEP: cover property (@(posedge clk) disable iff (rst)
        s_r.mode == scm_pkg::SCM_DEEP_SLEEP ##1 wake);
    COV_IDLE_ON: cover property (@(posedge clk) disable iff (rst)
        s_r.mode == scm_pkg::SCM_IDLE_CLOCK_ON && system_clk_en);
    COV_CLEAR: cover property (@(posedge clk) disable iff (rst)
        wr_flags && s_r.flags != 4'h0);
endmodule // scm_clock_mode_ctrl

/* File: testbench/scm_testbench.sv */
/*
 * Self-checking bench for the system clock and mode control block.
 * Assumes the block's own assertions sit in the design files.
 */
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [3:0] a; logic [7:0] d, r; int cs;} scm_tb_row_t;
    typedef struct {logic [7:0] m0, m1; logic w; int cs, cw, ct;
        logic fr, sr;} scm_tb_halt_t;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic halt = 1'b0, wake = 1'b0, fstab = 1'b0, sstab = 1'b0;
    logic wdt_en = 1'b0;
    logic [3:0] addr = 4'h0, ev = 4'h0, scnt = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic sys_en, cpu_en, d16, d64, wdt_ck, tb_en, f_run, s_run;
    logic halted, swr;
    int n_fail = 0, total_checks = 0;
    int c_sys, c_cpu, c16, c64, c_wdt, c_tb, c_sw;
    scm_tb_row_t rows[11] = '{
        '{4'h0, 8'h03, 8'h0f, 128}, '{4'h0, 8'h42, 8'h4e, 2},
        '{4'h0, 8'h62, 8'h6e, 4}, '{4'h0, 8'h82, 8'h8e, 8},
        '{4'h0, 8'ha2, 8'hae, 16}, '{4'h0, 8'hc2, 8'hce, 32},
        '{4'h0, 8'he2, 8'hee, 64}, '{4'h0, 8'hff, 8'hef, 128},
        '{4'h1, 8'hff, 8'h80, 128}, '{4'h1, 8'h00, 8'h00, 128},
        '{4'h2, 8'hff, 8'h00, 128}};
    scm_tb_halt_t hrows[4] = '{
        '{8'h03, 8'h80, 1'b0, 64, 4, 4, 1'b1, 1'b1},
        '{8'h03, 8'h00, 1'b0, 0, 4, 4, 1'b1, 1'b1},
        '{8'h01, 8'h00, 1'b1, 0, 4, 0, 1'b0, 1'b1},
        '{8'h01, 8'h00, 1'b0, 0, 0, 0, 1'b0, 1'b0}};

    scm_clock_mode_ctrl dut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .slow_clk_pin(scnt[3]), .fast_osc_stable_pin(fstab),
        .slow_osc_stable_pin(sstab), .halt(halt), .wake(wake),
        .wdt_enabled(wdt_en), .reset_ctrl_event(ev[3]),
        .low_volt_event(ev[2]), .wdt_ctrl_event(ev[0]),
        .voltage_reset_config_undefined(ev[1]), .system_clk_en(sys_en),
        .cpu_clk_en(cpu_en), .fast_div16_en(d16), .fast_div64_en(d64),
        .wdt_clk_en(wdt_ck), .time_base_en(tb_en), .fast_osc_run(f_run),
        .slow_osc_run(s_run), .cpu_halted(halted), .sw_reset_req(swr));

    always #20 clk = ~clk;
    // Slow oscillator freezes when the block stops it
    always @(posedge clk) if (s_run === 1'b1) scnt <= scnt + 4'h1;

    task chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task wreg(logic [3:0] a, logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task rchk(logic [3:0] a, logic [7:0] e);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) chk("rdata", rdata, e);
    endtask
    task count(int n);
        {c_sys, c_cpu, c16, c64, c_wdt, c_tb, c_sw} = '0;
        repeat (n) begin
            @(negedge clk);
            c_sys += (sys_en === 1'b1);
            c_cpu += (cpu_en === 1'b1);
            c16 += (d16 === 1'b1);
            c64 += (d64 === 1'b1);
            c_wdt += (wdt_ck === 1'b1);
            c_tb += (tb_en === 1'b1);
            c_sw += (swr === 1'b1);
        end
    endtask
    task test_done;
        $display("Checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bound of 20000 cycles, well above the whole sequence of a few thousand
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done;
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(4'h0, 8'h03);
        rchk(4'h1, 8'h00);
        @(posedge clk) fstab <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(4'h0, 8'h07);
        @(posedge clk) sstab <= 1'b1;
        repeat (48) @(posedge clk);
        rchk(4'h0, 8'h0f);
        $display("Test reset done");
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].r);
            // Longest divider needs one old tick before switching
            repeat (80) @(posedge clk);
            count(128);
            chk("sys_clk", c_sys, rows[i].cs);
            chk("cpu_clk", c_cpu, rows[i].cs);
            chk("div16", c16, 8);
            chk("div64", c64, 2);
        end
        $display("Test divider rows done");
        wreg(4'h0, 8'h00);
        repeat (200) @(posedge clk);
        // Fast oscillator is off under the slow clock, so not ready
        rchk(4'h0, 8'h08);
        count(128);
        chk("sys_clk", c_sys, 8);
        chk("div16", c16, 0);
        chk("div64", c64, 0);
        chk("fast_run", f_run, 1'b0);
        wreg(4'h0, 8'h01);
        rchk(4'h0, 8'h0d);
        repeat (100) @(posedge clk);
        count(128);
        chk("sys_clk", c_sys, 128);
        chk("fast_run", f_run, 1'b1);
        $display("Test slow switch done");
        foreach (hrows[i]) begin
            wreg(4'h0, hrows[i].m0);
            wreg(4'h1, hrows[i].m1);
            wdt_en <= hrows[i].w;
            @(posedge clk) halt <= 1'b1;
            @(posedge clk) halt <= 1'b0;
            @(negedge clk) chk("halted", halted, 1'b1);
            count(64);
            chk("sys_clk", c_sys, hrows[i].cs);
            chk("cpu_clk", c_cpu, 0);
            chk("wdt_clk", c_wdt, hrows[i].cw);
            chk("time_base", c_tb, hrows[i].ct);
            chk("fast_run", f_run, hrows[i].fr);
            chk("slow_run", s_run, hrows[i].sr);
            if (i == 3) rchk(4'h0, 8'h01);
            @(posedge clk) wake <= 1'b1;
            @(posedge clk) wake <= 1'b0;
            @(negedge clk) chk("halted", halted, 1'b0);
        end
        repeat (48) @(posedge clk);
        rchk(4'h0, 8'h0d);
        $display("Test halt modes done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) ev <= 4'h1 << i;
            count(4);
            chk("sw_reset", c_sw, i == 1);
            @(posedge clk) ev <= 4'h0;
            rchk(4'h1, 8'((2 << i) - 1));
        end
        wreg(4'h1, 8'h0f);
        rchk(4'h1, 8'h0f);
        // Clear and set in one cycle: the event must win
        @(posedge clk) begin addr <= 4'h1; wdata <= 8'h00; wr <= 1'b1;
            ev <= 4'h1; end
        @(posedge clk) begin wr <= 1'b0; ev <= 4'h0; end
        rchk(4'h1, 8'h01);
        @(posedge clk) rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(4'h1, 8'h00);
        count(64);
        chk("sys_clk", c_sys, 64);
        $display("Test flags and reset done");
        test_done;
    end
endmodule // testbench
